//--- pkg/fdoc_defs.svh
// Constants of the four-channel output control: codes, limits and timing
`ifndef FDOC_DEFS_SVH
`define FDOC_DEFS_SVH

// ======================================================================
// Output codes per range (full scale and permitted set value window)
`define FDOC_R15_MIN   16'sh0000
`define FDOC_R15_MAX   16'sh2710
`define FDOC_R15_LO    16'shFE0C
`define FDOC_R15_HI    16'sh2904
`define FDOC_R010_MIN  16'sh0000
`define FDOC_R010_MAX  16'sh4E20
`define FDOC_R010_LO   16'shFC18
`define FDOC_R010_HI   16'sh5208
`define FDOC_RBI_MIN   16'shB1E0
`define FDOC_RBI_MAX   16'sh4E20
`define FDOC_RBI_LO    16'shADF8
`define FDOC_RBI_HI    16'sh5208

// ======================================================================
// Scaling limits
`define FDOC_SCALE_MIN 16'sh8300
`define FDOC_SCALE_MAX 16'sh7D00

// ======================================================================
// Timing: conversion pass is base time plus one step per extra channel
`define FDOC_CLK_MHZ   25
`define FDOC_PASS1_US  20
`define FDOC_STEP_US   5
`define FDOC_PASS1_CYC (`FDOC_PASS1_US * `FDOC_CLK_MHZ)
`define FDOC_STEP_CYC  (`FDOC_STEP_US * `FDOC_CLK_MHZ)
`define FDOC_REFRESH_TIMEOUT_US 10000
`define FDOC_REFRESH_TIMEOUT_CYC (`FDOC_REFRESH_TIMEOUT_US * `FDOC_CLK_MHZ)

// ======================================================================
// Reset values of the configuration
`define FDOC_RST_CHANS 3'h4

`endif

//--- pkg/fdoc_pkg.sv
// Types of the four-channel output control
package fdoc_pkg;

   // Output range selection per channel
   typedef enum logic [1:0] {
      FDOC_RANGE_1_5V   = 2'b00,
      FDOC_RANGE_0_10V  = 2'b01,
      FDOC_RANGE_PM10V  = 2'b10,
      FDOC_RANGE_BAD    = 2'b11
   } fdoc_range_e;

   // Fallback behaviour on stop or error
   typedef enum logic [1:0] {
      FDOC_FB_ZERO = 2'b00,
      FDOC_FB_HOLD = 2'b01,
      FDOC_FB_MAX  = 2'b10,
      FDOC_FB_BAD  = 2'b11
   } fdoc_fallback_e;

   // Conversion sequencer states
   typedef enum logic [0:0] {
      FDOC_SEQ_IDLE = 1'b0,
      FDOC_SEQ_RUN  = 1'b1
   } fdoc_seq_e;

endpackage

//--- rtl/fdoc_scaler.sv
// Scaling and range check of one set value into an output code
`timescale 1ns/10ps
`include "fdoc_defs.svh"

module fdoc_scaler
(
   input  wire logic signed [15:0] set_value_i,
   input  wire logic        [1:0]  range_i,
   input  wire logic               scale_en_i,
   input  wire logic signed [15:0] scale_lower_i,
   input  wire logic signed [15:0] scale_upper_i,
   output logic signed      [15:0] code_o,
   output logic signed      [15:0] full_min_o,
   output logic signed      [15:0] full_max_o,
   output logic                    out_of_range_o
);

   logic signed [35:0] min_w;
   logic signed [35:0] max_w;
   logic signed [35:0] lo_w;
   logic signed [35:0] hi_w;
   logic signed [35:0] prod_w;
   logic signed [35:0] den_w;
   logic signed [35:0] res_w;

   // ======================================================================
   // Range table lookup
   always_comb
   begin
      case (fdoc_pkg::fdoc_range_e'(range_i))
         fdoc_pkg::FDOC_RANGE_1_5V:
         begin
            full_min_o = `FDOC_R15_MIN;
            full_max_o = `FDOC_R15_MAX;
            lo_w       = 36'(`FDOC_R15_LO);
            hi_w       = 36'(`FDOC_R15_HI);
         end
         fdoc_pkg::FDOC_RANGE_0_10V:
         begin
            full_min_o = `FDOC_R010_MIN;
            full_max_o = `FDOC_R010_MAX;
            lo_w       = 36'(`FDOC_R010_LO);
            hi_w       = 36'(`FDOC_R010_HI);
         end
         default:
         begin
            full_min_o = `FDOC_RBI_MIN;
            full_max_o = `FDOC_RBI_MAX;
            lo_w       = 36'(`FDOC_RBI_LO);
            hi_w       = 36'(`FDOC_RBI_HI);
         end
      endcase
   end

   // ======================================================================
   // Linear map of lower..upper onto the full scale, then window check
   always_comb
   begin
      min_w  = 36'(full_min_o);
      max_w  = 36'(full_max_o);
      den_w  = 36'(scale_upper_i) - 36'(scale_lower_i);
      prod_w = (36'(set_value_i) - 36'(scale_lower_i)) * (max_w - min_w);
      if (!scale_en_i)
         res_w = 36'(set_value_i);
      else if (den_w == 36'sh0)                       // Invalid limits, caught as config error
         res_w = min_w;
      else
         res_w = min_w + prod_w / den_w;
      out_of_range_o = (res_w < lo_w) || (res_w > hi_w);
      code_o         = res_w[15:0];
   end

endmodule

//--- rtl/fdoc_top.sv
// Four-channel analog output control: refresh latch, sequencer, fallback, indicators
`timescale 1ns/10ps
`include "fdoc_defs.svh"

module fdoc_top
#(
   parameter int REFRESH_TIMEOUT_CYC = `FDOC_REFRESH_TIMEOUT_CYC
)
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        refresh_i,
   input  wire logic [15:0] set_value0_i,
   input  wire logic [15:0] set_value1_i,
   input  wire logic [15:0] set_value2_i,
   input  wire logic [15:0] set_value3_i,
   input  wire logic [3:0]  conv_permit_i,
   input  wire logic        run_mode_i,
   input  wire logic        major_fault_i,
   input  wire logic        link_error_i,
   input  wire logic        cfg_load_i,
   input  wire logic [2:0]  channels_in_use_setting_i,
   input  wire logic [7:0]  channel_range_setting_i,
   input  wire logic [1:0]  fallback_mode_i,
   input  wire logic        scale_en_i,
   input  wire logic [15:0] scale_lower_i,
   input  wire logic [15:0] scale_upper_i,
   output logic      [15:0] dac_code0_o,
   output logic      [15:0] dac_code1_o,
   output logic      [15:0] dac_code2_o,
   output logic      [15:0] dac_code3_o,
   output logic      [3:0]  dac_load_o,
   output logic      [3:0]  setting_error_o,
   output logic      [3:0]  permit_o,
   output logic             pass_done_o,
   output logic             run_indicator_o,
   output logic             module_error_indicator_o,
   output logic             host_error_indicator_o
);

   localparam logic [9:0] PASS1_CYC = 10'(`FDOC_PASS1_CYC);
   localparam logic [9:0] STEP_CYC  = 10'(`FDOC_STEP_CYC);

   // ======================================================================
   // Elaboration checks
   if (REFRESH_TIMEOUT_CYC < 1 || REFRESH_TIMEOUT_CYC > 1048575)
   begin : g_bad_timeout
      $error("REFRESH_TIMEOUT_CYC must lie in 1..1048575");
   end

   // Configuration state
   logic        [2:0]  chans_q,  chans_d;
   logic        [7:0]  range_q,  range_d;
   logic        [1:0]  fb_q,     fb_d;
   logic               sc_en_q,  sc_en_d;
   logic signed [15:0] sc_lo_q,  sc_lo_d;
   logic signed [15:0] sc_hi_q,  sc_hi_d;
   logic               loaded_q, loaded_d;
   logic               cfg_ok_w;

   // Host exchange state
   logic signed [15:0] setv_q [4], setv_d [4];
   logic        [3:0]  permit_q,  permit_d;
   logic               run_mode_q, run_mode_d;
   logic        [19:0] idle_q,    idle_d;
   logic               run_q,     run_d;
   logic               merr_q,    merr_d;
   logic               herr_q,    herr_d;

   // Sequencer and output state
   fdoc_pkg::fdoc_seq_e seq_q, seq_d;
   logic        [9:0]  pcnt_q,  pcnt_d;
   logic        [2:0]  ch_q,    ch_d;
   logic signed [15:0] code_q [4], code_d [4];
   logic        [3:0]  load_q,  load_d;
   logic        [3:0]  err_q,   err_d;
   logic               done_q,  done_d;

   // Scaler interface
   logic signed [15:0] sv_w;
   logic        [1:0]  rng_w;
   logic signed [15:0] sc_code_w, fmin_w, fmax_w;
   logic               oor_w;
   logic        [9:0]  pass_len_w, slot_w;

   // ======================================================================
   // Configuration: validity of the captured settings
   always_comb
   begin
      cfg_ok_w = (chans_q != 3'h0) && (chans_q <= 3'h4);
      for (int i = 0; i < 4; i++)
      begin
         if ((3'(i) < chans_q) && (range_q[2*i +: 2] == 2'b11))
            cfg_ok_w = 1'b0;
      end
      if (fb_q == 2'b11)
         cfg_ok_w = 1'b0;
      if (sc_en_q && ((sc_lo_q == sc_hi_q) ||
                      (sc_lo_q < `FDOC_SCALE_MIN) || (sc_lo_q > `FDOC_SCALE_MAX) ||
                      (sc_hi_q < `FDOC_SCALE_MIN) || (sc_hi_q > `FDOC_SCALE_MAX)))
         cfg_ok_w = 1'b0;
   end

   // Configuration capture only on load strobe
   always_comb
   begin
      chans_d  = chans_q;
      range_d  = range_q;
      fb_d     = fb_q;
      sc_en_d  = sc_en_q;
      sc_lo_d  = sc_lo_q;
      sc_hi_d  = sc_hi_q;
      loaded_d = loaded_q;
      if (cfg_load_i)
      begin
         chans_d  = channels_in_use_setting_i;
         range_d  = channel_range_setting_i;
         fb_d     = fallback_mode_i;
         sc_en_d  = scale_en_i;
         sc_lo_d  = scale_lower_i;
         sc_hi_d  = scale_upper_i;
         loaded_d = 1'b1;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         chans_q  <= `FDOC_RST_CHANS;
         range_q  <= 8'h00;
         fb_q     <= 2'h0;
         sc_en_q  <= 1'b0;
         sc_lo_q  <= 16'sh0000;
         sc_hi_q  <= 16'sh0000;
         loaded_q <= 1'b0;
      end
      else
      begin
         chans_q  <= chans_d;
         range_q  <= range_d;
         fb_q     <= fb_d;
         sc_en_q  <= sc_en_d;
         sc_lo_q  <= sc_lo_d;
         sc_hi_q  <= sc_hi_d;
         loaded_q <= loaded_d;
      end
   end

   // ======================================================================
   // Host exchange: refresh latch, permit flags, indicators
   always_comb
   begin
      setv_d     = setv_q;
      permit_d   = permit_q;
      run_mode_d = run_mode_i;
      idle_d     = idle_q;
      if (run_mode_q && !run_mode_i)
         permit_d = 4'h0;
      if (refresh_i)                                   // Refresh wins over the clear
      begin
         setv_d[0] = set_value0_i;
         setv_d[1] = set_value1_i;
         setv_d[2] = set_value2_i;
         setv_d[3] = set_value3_i;
         permit_d  = conv_permit_i;
         idle_d    = 20'h00000;
      end
      else if (idle_q < 20'(REFRESH_TIMEOUT_CYC))
         idle_d = idle_q + 20'h00001;
      run_d  = loaded_q && cfg_ok_w && (idle_q < 20'(REFRESH_TIMEOUT_CYC));
      merr_d = loaded_q && !cfg_ok_w;
      herr_d = link_error_i;
   end

   // Host exchange registers
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < 4; i++)
            setv_q[i] <= 16'sh0000;
         permit_q   <= 4'h0;
         run_mode_q <= 1'b0;
         idle_q     <= 20'hFFFFF;
         run_q      <= 1'b0;
         merr_q     <= 1'b0;
         herr_q     <= 1'b0;
      end
      else
      begin
         setv_q     <= setv_d;
         permit_q   <= permit_d;
         run_mode_q <= run_mode_d;
         idle_q     <= idle_d;
         run_q      <= run_d;
         merr_q     <= merr_d;
         herr_q     <= herr_d;
      end
   end

   // ======================================================================
   // Scaler for the channel in its conversion slot
   assign sv_w       = setv_q[ch_q[1:0]];
   assign rng_w      = range_q[2*ch_q[1:0] +: 2];
   assign pass_len_w = PASS1_CYC + 10'(STEP_CYC * 10'(chans_q - 3'h1));
   assign slot_w     = 10'(STEP_CYC * 10'(ch_q));

   fdoc_scaler u_scaler
   (
      .set_value_i    (sv_w),
      .range_i        (rng_w),
      .scale_en_i     (sc_en_q),
      .scale_lower_i  (sc_lo_q),
      .scale_upper_i  (sc_hi_q),
      .code_o         (sc_code_w),
      .full_min_o     (fmin_w),
      .full_max_o     (fmax_w),
      .out_of_range_o (oor_w)
   );

   // ======================================================================
   // Sequencer: one slot per used channel, pass ends at its fixed length
   always_comb
   begin
      seq_d  = seq_q;
      pcnt_d = pcnt_q;
      ch_d   = ch_q;
      code_d = code_q;
      load_d = 4'h0;
      err_d  = err_q;
      done_d = 1'b0;
      case (seq_q)
         fdoc_pkg::FDOC_SEQ_IDLE:
         begin
            pcnt_d = 10'h000;
            ch_d   = 3'h0;
            if (loaded_q && cfg_ok_w)
               seq_d = fdoc_pkg::FDOC_SEQ_RUN;
         end
         fdoc_pkg::FDOC_SEQ_RUN:
         begin
            if (!(loaded_q && cfg_ok_w))
               seq_d = fdoc_pkg::FDOC_SEQ_IDLE;
            else
            begin
               if ((ch_q < chans_q) && (pcnt_q == slot_w))
               begin
                  err_d[ch_q[1:0]]  = oor_w;
                  load_d[ch_q[1:0]] = 1'b1;
                  if (!permit_q[ch_q[1:0]] || major_fault_i || oor_w)
                  begin
                     case (fdoc_pkg::fdoc_fallback_e'(fb_q))
                        fdoc_pkg::FDOC_FB_ZERO: code_d[ch_q[1:0]] = fmin_w;
                        fdoc_pkg::FDOC_FB_MAX:  code_d[ch_q[1:0]] = fmax_w;
                        default:                load_d[ch_q[1:0]] = 1'b0; // Hold: keep code
                     endcase
                  end
                  else
                     code_d[ch_q[1:0]] = sc_code_w;
                  ch_d = ch_q + 3'h1;
               end
               if (pcnt_q >= pass_len_w - 10'h001)
               begin
                  pcnt_d = 10'h000;
                  ch_d   = 3'h0;
                  done_d = 1'b1;
               end
               else
                  pcnt_d = pcnt_q + 10'h001;
            end
         end
         default:
         begin
            seq_d = fdoc_pkg::FDOC_SEQ_IDLE;
         end
      endcase
   end

   // Sequencer and output registers
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         seq_q  <= fdoc_pkg::FDOC_SEQ_IDLE;
         pcnt_q <= 10'h000;
         ch_q   <= 3'h0;
         for (int i = 0; i < 4; i++)
            code_q[i] <= 16'sh0000;
         load_q <= 4'h0;
         err_q  <= 4'h0;
         done_q <= 1'b0;
      end
      else
      begin
         seq_q  <= seq_d;
         pcnt_q <= pcnt_d;
         ch_q   <= ch_d;
         code_q <= code_d;
         load_q <= load_d;
         err_q  <= err_d;
         done_q <= done_d;
      end
   end

   // ======================================================================
   // Outputs straight from registers
   assign dac_code0_o              = code_q[0];
   assign dac_code1_o              = code_q[1];
   assign dac_code2_o              = code_q[2];
   assign dac_code3_o              = code_q[3];
   assign dac_load_o               = load_q;
   assign setting_error_o          = err_q;
   assign permit_o                 = permit_q;
   assign pass_done_o              = done_q;
   assign run_indicator_o          = run_q;
   assign module_error_indicator_o = merr_q;
   assign host_error_indicator_o   = herr_q;

endmodule

//--- tb/fdoc_host_model.sv
// Host controller model: periodic one-cycle I/O refresh strobe
`timescale 1ns/10ps

module fdoc_host_model
#(
   parameter int PERIOD = 20
)
(
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   output logic      refresh_o
);
   logic [7:0] tick_q;
   logic [7:0] tick_d;

   // One task period between refreshes
   always_comb
   begin
      tick_d = (tick_q == 8'(PERIOD - 1)) ? 8'h00 : tick_q + 8'h01;
   end

   // Strobe while the host exchanges data
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         tick_q    <= 8'h00;
         refresh_o <= 1'b0;
      end
      else
      begin
         tick_q    <= tick_d;
         refresh_o <= enable_i && tick_q == 8'h00;
      end
   end
endmodule

//--- tb/fdoc_top_chk.sv
// Assertion checker bound to the four-channel output control top
`timescale 1ns/10ps
`include "fdoc_defs.svh"

module fdoc_top_chk
#(
   parameter int REFRESH_TIMEOUT_CYC = `FDOC_REFRESH_TIMEOUT_CYC
)
(
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic        refresh_i,
   input wire logic [15:0] set_value0_i,
   input wire logic [3:0]  conv_permit_i,
   input wire logic        run_mode_i,
   input wire logic        major_fault_i,
   input wire logic        link_error_i,
   input wire logic        cfg_load_i,
   input wire logic [2:0]  channels_in_use_setting_i,
   input wire logic [7:0]  channel_range_setting_i,
   input wire logic [1:0]  fallback_mode_i,
   input wire logic        scale_en_i,
   input wire logic [15:0] dac_code0_o,
   input wire logic [3:0]  dac_load_o,
   input wire logic [3:0]  setting_error_o,
   input wire logic [3:0]  permit_o,
   input wire logic        pass_done_o,
   input wire logic        run_indicator_o,
   input wire logic        module_error_indicator_o,
   input wire logic        host_error_indicator_o
);
   logic [2:0]  chans_q;
   logic [1:0]  rng0_q, fb_q;
   logic        scl_q, seen_q, bad_w;
   logic [15:0] sv0_q, cnt_q, fb_code_w;
   logic [19:0] idle_q;

   // Settings the design must refuse, and the fallback code of channel 0
   assign bad_w = channels_in_use_setting_i == 3'h0 || channels_in_use_setting_i > 3'h4
                  || fallback_mode_i == 2'h3
                  || (channel_range_setting_i & (channel_range_setting_i >> 1)
                      & (8'h55 >> (2 * (3'h4 - channels_in_use_setting_i)))) != 8'h00;
   assign fb_code_w = fb_q == 2'h2 ? (rng0_q == 2'h0 ? `FDOC_R15_MAX : `FDOC_R010_MAX)
                      : (rng0_q == 2'h2 ? `FDOC_RBI_MIN : 16'h0000);

   // Shadow of configuration, latched value and pass timing
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         chans_q <= `FDOC_RST_CHANS;
         rng0_q  <= 2'h0;
         fb_q    <= 2'h0;
         scl_q   <= 1'b0;
         sv0_q   <= 16'h0000;
         seen_q  <= 1'b0;
         idle_q  <= 20'h00000;
      end
      else
      begin
         if (cfg_load_i)
         begin
            chans_q <= channels_in_use_setting_i;
            rng0_q  <= channel_range_setting_i[1:0];
            fb_q    <= fallback_mode_i;
            scl_q   <= scale_en_i;
         end
         if (refresh_i)
            sv0_q <= set_value0_i;
         seen_q <= !cfg_load_i && (seen_q || pass_done_o);
         idle_q <= refresh_i ? 20'h00000 : idle_q + {19'h00000, idle_q != 20'hFFFFF};
      end
      cnt_q <= pass_done_o ? 16'h0001 : cnt_q + 16'h0001;
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_cfg_taken;
      cfg_load_i && !scale_en_i;
   endsequence
   sequence s_pass_seen;
      pass_done_o && seen_q;
   endsequence

   property p_reset_clear;
      disable iff (1'b0) reset_i |=> {dac_code0_o, dac_load_o, permit_o} == 24'h0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
   property p_permit_take;
      refresh_i |=> permit_o == $past(conv_permit_i);
   endproperty
   a_permit_take: assert property (p_permit_take) else $error("permit not latched");
   property p_permit_drop;
      $fell(run_mode_i) && !refresh_i |=> permit_o == 4'h0;
   endproperty
   a_permit_drop: assert property (p_permit_drop) else $error("permit kept");
   property p_fallback;
      dac_load_o[0] && (!$past(permit_o[0]) || $past(major_fault_i))
         |-> dac_code0_o == $past(fb_code_w);
   endproperty
   a_fallback: assert property (p_fallback) else $error("wrong fallback code");
   property p_follow;
      dac_load_o[0] && $past(permit_o[0]) && !$past(major_fault_i) && !setting_error_o[0]
         && !$past(scl_q) |-> dac_code0_o == $past(sv0_q);
   endproperty
   a_follow: assert property (p_follow) else $error("code does not follow value");
   property p_slot;
      dac_load_o != 4'h0 && seen_q |-> (cnt_q - 16'h1) % 16'h7D == 16'h0
         && dac_load_o == 4'h1 << ((cnt_q - 16'h1) / 16'h7D)
         && (cnt_q - 16'h1) / 16'h7D < 16'(chans_q);
   endproperty
   a_slot: assert property (p_slot) else $error("load outside its slot");
   property p_pass_len;
      s_pass_seen |-> cnt_q == 16'h1F4 + 16'h7D * (16'(chans_q) - 16'h1);
   endproperty
   a_pass_len: assert property (p_pass_len) else $error("wrong pass length");
   property p_cfg_err;
      s_cfg_taken |-> ##2 module_error_indicator_o == $past(bad_w, 2);
   endproperty
   a_cfg_err: assert property (p_cfg_err) else $error("module error wrong");
   property p_host_err;
      !$past(reset_i) |-> host_error_indicator_o == $past(link_error_i);
   endproperty
   a_host_err: assert property (p_host_err) else $error("host error wrong");
   property p_run_off;
      idle_q > 20'(REFRESH_TIMEOUT_CYC + 1) || module_error_indicator_o |-> !run_indicator_o;
   endproperty
   a_run_off: assert property (p_run_off) else $error("run lit wrongly");
endmodule

bind fdoc_top fdoc_top_chk #(.REFRESH_TIMEOUT_CYC(REFRESH_TIMEOUT_CYC)) i_fdoc_top_chk (.*);

//--- tb/test_four_channel_dac_output_control.sv
// Self-checking bench of the four-channel output control
`timescale 1ns/10ps

`define CHK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) \
      begin \
         err_count++; \
         $display("BAD %s exp %h got %h", nm, ex, got); \
      end \
   end

module test_four_channel_dac_output_control;
   typedef struct packed {
      logic [1:0]  rng;
      logic [1:0]  fb;
      logic        perm;
      logic        scl;
      logic [15:0] sv;
      logic [15:0] code;
      logic        err;
   } fdoc_row_s;

   logic        mclk_i, reset_i, refresh_i, run_mode_i, major_fault_i, link_error_i;
   logic        cfg_load_i, scale_en_i, host_en, pass_done_o, run_indicator_o;
   logic        module_error_indicator_o, host_error_indicator_o;
   logic [15:0] set_value0_i, set_value1_i, set_value2_i, set_value3_i;
   logic [15:0] scale_lower_i, scale_upper_i, dac_code0_o, dac_code1_o, dac_code2_o, dac_code3_o;
   logic [3:0]  conv_permit_i, dac_load_o, setting_error_o, permit_o;
   logic [2:0]  channels_in_use_setting_i;
   logic [7:0]  channel_range_setting_i;
   logic [1:0]  fallback_mode_i;
   int          err_count, checks_done, n;
   logic [12:0] bad [4] = '{13'h0000, 13'h1400, 13'h040C, 13'h0403};
   fdoc_row_s   rows [8] = '{
      '{2'h1, 2'h0, 1'h1, 1'h0, 16'h1234, 16'h1234, 1'h0},
      '{2'h0, 2'h0, 1'h0, 1'h0, 16'h0064, 16'h0000, 1'h0},
      '{2'h0, 2'h2, 1'h0, 1'h0, 16'h0064, 16'h2710, 1'h0},
      '{2'h2, 2'h0, 1'h0, 1'h0, 16'h0064, 16'hB1E0, 1'h0},
      '{2'h2, 2'h2, 1'h1, 1'h0, 16'h5209, 16'h4E20, 1'h1},
      '{2'h1, 2'h0, 1'h1, 1'h0, 16'hFC17, 16'h0000, 1'h1},
      '{2'h0, 2'h0, 1'h1, 1'h0, 16'h2904, 16'h2904, 1'h0},
      '{2'h1, 2'h0, 1'h1, 1'h1, 16'h01F4, 16'h3A98, 1'h0}};

   fdoc_top #(.REFRESH_TIMEOUT_CYC(50)) i_fdoc_top (.*);
   fdoc_host_model #(.PERIOD(20)) i_fdoc_host_model
   (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .enable_i  (host_en),
      .refresh_o (refresh_i)
   );

   // Clock of 40 ns period
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Loads a configuration with a one-cycle strobe
   task automatic cfg(input logic [2:0] c, input logic [7:0] r, input logic [1:0] f,
                      input logic s);
      @(posedge mclk_i);
      channels_in_use_setting_i <= c;
      channel_range_setting_i   <= r;
      fallback_mode_i           <= f;
      scale_en_i                <= s;
      cfg_load_i                <= 1'b1;
      @(posedge mclk_i);
      cfg_load_i <= 1'b0;
   endtask

   // Waits for a channel load (0..3) or pass end (4), bounded
   task automatic wait_evt(input int k, output int cyc);
      cyc = 0;
      do
      begin
         @(negedge mclk_i);
         cyc++;
      end
      while (!(k < 4 ? dac_load_o[k] === 1'b1 : pass_done_o === 1'b1) && cyc < 2000);
      if (cyc >= 2000)
      begin
         err_count++;
         test_done();
      end
   endtask

   // Main sequence
   initial
   begin
      {err_count, checks_done} = '0;
      {reset_i, host_en, run_mode_i} = 3'h7;
      {major_fault_i, link_error_i, cfg_load_i, scale_en_i, fallback_mode_i} = '0;
      {set_value0_i, set_value1_i, set_value2_i, set_value3_i, conv_permit_i} = '0;
      {channels_in_use_setting_i, channel_range_setting_i} = '0;
      scale_lower_i = 16'hFC18;
      scale_upper_i = 16'h03E8;
      repeat (5) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(negedge mclk_i);
      `CHK("reset outputs", 24'h0, {dac_code0_o, dac_load_o, permit_o})
      @(posedge mclk_i);
      set_value1_i  <= 16'h0100;
      set_value3_i  <= 16'h4E20;
      conv_permit_i <= 4'hA;
      cfg(3'h2, 8'h46, 2'h0, 1'h0);
      repeat (2) wait_evt(4, n);
      `CHK("two channel pass", 625, n)
      `CHK("unused codes", 32'h0, {dac_code2_o, dac_code3_o})
      cfg(3'h4, 8'h46, 2'h0, 1'h0);
      repeat (3) wait_evt(4, n);
      `CHK("four channel pass", 875, n)
      `CHK("mixed ranges", 64'hB1E0_0100_0000_4E20, {dac_code0_o, dac_code1_o, dac_code2_o, dac_code3_o})
      foreach (rows[i])
      begin
         @(posedge mclk_i);
         set_value0_i  <= rows[i].sv;
         conv_permit_i <= {3'h0, rows[i].perm};
         cfg(3'h1, {6'h00, rows[i].rng}, rows[i].fb, rows[i].scl);
         repeat (2) wait_evt(0, n);
         `CHK("row code", rows[i].code, dac_code0_o)
         `CHK("row error", rows[i].err, setting_error_o[0])
      end
      @(posedge mclk_i);
      set_value0_i  <= 16'h0777;
      conv_permit_i <= 4'h1;
      cfg(3'h1, 8'h01, 2'h1, 1'h0);
      repeat (2) wait_evt(0, n);
      @(posedge mclk_i);
      conv_permit_i <= 4'h0;
      repeat (40) @(negedge mclk_i);
      n = 0;
      repeat (1100)
      begin
         @(negedge mclk_i);
         n += int'(dac_load_o[0] === 1'b1);
      end
      `CHK("hold loads", 0, n)
      `CHK("hold code", 16'h0777, dac_code0_o)
      @(posedge mclk_i);
      conv_permit_i <= 4'h1;
      major_fault_i <= 1'b1;
      cfg(3'h1, 8'h01, 2'h2, 1'h0);
      repeat (2) wait_evt(0, n);
      `CHK("fault code", 16'h4E20, dac_code0_o)
      @(posedge mclk_i);
      major_fault_i <= 1'b0;
      link_error_i  <= 1'b1;
      repeat (2) @(negedge mclk_i);
      `CHK("host error lit", 1'b1, host_error_indicator_o)
      `CHK("run lit", 1'b1, run_indicator_o)
      `CHK("module error off", 1'b0, module_error_indicator_o)
      @(posedge mclk_i);
      link_error_i <= 1'b0;
      host_en      <= 1'b0;
      repeat (3) @(posedge mclk_i);
      run_mode_i <= 1'b0;
      repeat (60) @(negedge mclk_i);
      `CHK("host error off", 1'b0, host_error_indicator_o)
      `CHK("permit dropped", 4'h0, permit_o)
      `CHK("run off", 1'b0, run_indicator_o)
      foreach (bad[i])
      begin
         cfg(bad[i][12:10], bad[i][9:2], bad[i][1:0], 1'h0);
         repeat (3) @(negedge mclk_i);
         `CHK("module error", 1'b1, module_error_indicator_o)
      end
      @(posedge mclk_i);
      scale_upper_i <= 16'hFC18;
      cfg(3'h1, 8'h00, 2'h0, 1'h1);
      repeat (3) @(negedge mclk_i);
      `CHK("equal scale limits", 1'b1, module_error_indicator_o)
      @(posedge mclk_i);
      {run_mode_i, host_en} <= 2'h3;
      conv_permit_i <= 4'hF;
      cfg(3'h1, 8'h00, 2'h0, 1'h0);
      repeat (100) @(negedge mclk_i);
      `CHK("permit latched", 4'hF, permit_o)
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (2) @(negedge mclk_i);
      `CHK("permit after reset", 4'h0, permit_o)
      test_done();
   end
endmodule
